// ==== bench/ecm_ctl_model.sv ====
// Fieldbus controller model: parameter requests and supply pressure.
// Assumes requests are held one cycle and answered one cycle later.
`timescale 1ns/1ps
`default_nettype none
module ecm_ctl_model
	import ecm_pkg::*;
(
	// Clock
	input wire logic         clk,
	// Parameter port
	output ecm_req_s         par_req,
	input wire ecm_rsp_s     par_rsp,
	// Process data
	output logic             press_valid,
	output logic [15:0]      press_level
);
	initial begin
		par_req = '0;
		press_valid = 1'b0;
		press_level = 16'h0000;
	end
	// Range relations are not checked here, so refusals can be provoked
	task automatic xfer(input logic wr, input logic [15:0] ofs, input logic [3:0] idx,
		input logic [15:0] wd, output ecm_rsp_s rsp);
		@(posedge clk);
		#1;
		par_req = '{wr: wr, rd: !wr, ofs: ofs, idx: idx, wdata: wd};
		@(posedge clk);
		#1;
		rsp = par_rsp;
		par_req = '0;
	endtask
	task automatic set_press(input logic v, input logic [15:0] l);
		press_valid = v;
		press_level = l;
	endtask
endmodule // ecm_ctl_model
`default_nettype wire

// ==== bench/ecm_monitor_monitor.sv ====
// Port-level assertions for the ejector condition monitor.
// Assumes a single clk domain with the asynchronous arst_n reset.
`timescale 1ns/1ps
`default_nettype none
module ecm_checker
	import ecm_pkg::*;
#(
	parameter int unsigned N_EJ = 16
) (
	// Clock and reset
	input wire logic            clk,
	input wire logic            arst_n,
	// Parameter port
	input wire ecm_req_s        par_req,
	input wire ecm_rsp_s        par_rsp,
	// Supply and pressure
	input wire logic            us_under,
	input wire logic            us_over,
	input wire logic            ua_under,
	input wire logic            ua_over,
	input wire logic            press_valid,
	input wire logic [15:0]     press_level,
	// Outputs
	input wire logic [N_EJ-1:0] valve_drive,
	input wire logic [7:0]      cu_condition,
	input wire logic            volt_fault,
	input wire logic            bus_led,
	input wire logic [15:0]     eff_pressure
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// ==========
	// Parameter port
	a_req_acked: assert property ((par_req.wr || par_req.rd) |=> par_rsp.ack)
		else $error("request without answer");
	a_idle_quiet: assert property (!(par_req.wr || par_req.rd) |=> !par_rsp.ack)
		else $error("answer without request");
	a_ro_refused: assert property ((par_req.wr && par_req.ofs == OFS_COND) |=> par_rsp.err)
		else $error("write to condition bytes accepted");
	a_err_paired: assert property (par_rsp.err |-> par_rsp.ack)
		else $error("error flag outside answer");
	// ==========
	// Supply supervision, four cycles covers the pin synchroniser
	a_under_stops: assert property ((us_under || ua_under) [*4] |-> valve_drive == '0)
		else $error("valves driven on undervoltage");
	a_fault_seen: assert property ((us_under || ua_over) [*4] |-> volt_fault)
		else $error("supply fault not shown");
	a_over_flagged: assert property (us_over [*4] |-> cu_condition[CU_US])
		else $error("overvoltage not flagged");
	a_led_steady: assert property (!(us_under || us_over || ua_under || ua_over) [*5] |-> bus_led)
		else $error("bus indicator not steady");
	a_spare_zero: assert property (cu_condition[7:4] == 4'h0 && !cu_condition[2])
		else $error("spare unit condition bits set");
	a_press_taken: assert property ($past(arst_n) |->
		eff_pressure == ($past(press_valid) ? $past(press_level) : OPT_PRESS))
		else $error("effective pressure wrong");
endmodule // ecm_checker
bind ecm_monitor ecm_checker #(.N_EJ(N_EJ)) u_chk (.clk(clk), .arst_n(arst_n), .par_req(par_req),
	.par_rsp(par_rsp), .us_under(us_under), .us_over(us_over), .ua_under(ua_under), .ua_over(ua_over),
	.press_valid(press_valid), .press_level(press_level), .valve_drive(valve_drive),
	.cu_condition(cu_condition), .volt_fault(volt_fault), .bus_led(bus_led), .eff_pressure(eff_pressure));
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for ecm_monitor with shortened millisecond tick.
// Assumes ecm_ctl_model drives the parameter port.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ecm_pkg::*;
	typedef struct packed {
		logic        wr;
		logic [15:0] ofs;
		logic [3:0]  idx;
		logic [15:0] wd;
		logic        err;
		logic [15:0] rd;
	} ecm_row_s;
	logic clk = 0, arst_n = 0, us_under = 0, us_over = 0, ua_under = 0, ua_over = 0;
	logic [15:0] suck_req = 0, air_save_en = 0, leak_mon_en = 0, fallback_dis = 0;
	logic [15:0] manual_req = 0, manual_valve = 0, valve_drive, check_led, ctrl_reached;
	logic [255:0] vac = 0;
	logic [15:0] evac_ms = 16'h0002, eff_pressure;
	logic [7:0] cu_condition, cb;
	logic volt_fault, status_yellow, bus_led, press_valid;
	logic [15:0] press_level;
	ecm_req_s par_req;
	ecm_rsp_s par_rsp, r;
	int err_count = 0, comparisons = 0;
	ecm_row_s rows[19] = '{
		'{0, 16'h0064, 4'h0, 16'h0, 0, 16'h02ee}, '{0, 16'h0065, 4'hf, 16'h0, 0, 16'h0096},
		'{0, 16'h0066, 4'h0, 16'h0, 0, 16'h0226}, '{0, 16'h0067, 4'h0, 16'h0, 0, 16'h000a},
		'{0, 16'h0092, 4'hf, 16'h0, 0, 16'h0000}, '{1, 16'h0064, 4'h3, 16'h03e7, 1, 16'h0},
		'{1, 16'h0064, 4'h3, 16'h02bb, 1, 16'h0}, '{1, 16'h0064, 4'h3, 16'h0320, 0, 16'h0},
		'{0, 16'h0064, 4'h3, 16'h0, 0, 16'h0320}, '{1, 16'h0065, 4'h3, 16'h000a, 1, 16'h0},
		'{1, 16'h0065, 4'h3, 16'h000b, 0, 16'h0}, '{1, 16'h0066, 4'h3, 16'h000b, 1, 16'h0},
		'{1, 16'h0067, 4'h3, 16'h0009, 1, 16'h0}, '{1, 16'h0067, 4'h3, 16'h0064, 0, 16'h0},
		'{0, 16'h0067, 4'h3, 16'h0, 0, 16'h0064}, '{1, 16'h0092, 4'h3, 16'h0001, 1, 16'h0},
		'{0, 16'h0070, 4'h3, 16'h0, 1, 16'h0000}, '{1, 16'h0064, 4'h3, 16'h03e6, 0, 16'h0},
		'{0, 16'h0064, 4'h3, 16'h0, 0, 16'h03e6}};
	always #10 clk = ~clk;
	ecm_ctl_model ctl (.clk(clk), .par_req(par_req), .par_rsp(par_rsp), .press_valid(press_valid),
		.press_level(press_level));
	// One millisecond is ten cycles so the windows stay short
	ecm_monitor #(.N_EJ(16), .TICK_CYCLES(10), .WIN_MS(30), .LEAK_PER_MS(5)) DUT (.clk(clk),
		.arst_n(arst_n), .par_req(par_req), .par_rsp(par_rsp), .suck_req(suck_req),
		.air_save_en(air_save_en), .leak_mon_en(leak_mon_en), .fallback_dis(fallback_dis),
		.manual_req(manual_req), .manual_valve(manual_valve), .vacuum(vac), .evac_limit_ms(evac_ms),
		.leak_limit(16'h0064), .press_valid(press_valid), .press_level(press_level), .us_under(us_under),
		.us_over(us_over), .ua_under(ua_under), .ua_over(ua_over), .valve_drive(valve_drive),
		.check_led(check_led), .ctrl_reached(ctrl_reached), .cu_condition(cu_condition),
		.volt_fault(volt_fault), .status_yellow(status_yellow), .bus_led(bus_led),
		.eff_pressure(eff_pressure));
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("unexpected at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rc(input logic [3:0] g);
		ctl.xfer(1'b0, OFS_COND, g, 16'h0, r);
		cb = r.rdata[7:0];
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		results();
	end
	// ==========
	// Main sequence
	initial begin
		cyc(20);
		arst_n = 1;
		foreach (rows[i]) begin
			ctl.xfer(rows[i].wr, rows[i].ofs, rows[i].idx, rows[i].wd, r);
			chk(r.err, rows[i].err);
			if (!rows[i].wr) chk(r.rdata, rows[i].rd);
		end
		$display("test parameter table done");
		air_save_en[0] = 1;
		suck_req[0] = 1;
		cyc(3);
		chk(valve_drive[0], 1);
		vac[15:0] = 16'd600;
		cyc(3);
		chk(check_led[0], 1);
		cyc(40);
		vac[15:0] = 16'd800;
		cyc(3);
		chk(valve_drive[0], 0);
		chk(ctrl_reached[0], 1);
		chk(status_yellow, 1);
		vac[15:0] = 16'd590;
		cyc(3);
		chk(valve_drive[0], 1);
		chk(check_led[0], 1);
		chk(ctrl_reached[0], 0);
		suck_req[0] = 0;
		cyc(2);
		rc(0);
		chk(cb[CB_EVAC], 1);
		chk(cb[CB_THR], 0);
		$display("test evacuation done");
		vac[31:16] = 16'd600;
		suck_req[1] = 1;
		cyc(5);
		suck_req[1] = 0;
		cyc(3);
		rc(1);
		chk(cb[CB_THR], 1);
		cyc(5);
		rc(1);
		chk(cb[CB_THR], 1);
		suck_req[1] = 1;
		cyc(3);
		rc(1);
		chk(cb[CB_THR], 0);
		suck_req[1] = 0;
		$display("test threshold done");
		// Ejector 7 runs the same pattern with the fallback switched off
		air_save_en[2] = 1;
		air_save_en[7] = 1;
		fallback_dis[7] = 1;
		suck_req[2] = 1;
		suck_req[7] = 1;
		repeat (4) begin
			vac[47:32] = 16'd800;
			vac[127:112] = 16'd800;
			cyc(8);
			vac[47:32] = 16'd500;
			vac[127:112] = 16'd500;
			cyc(8);
		end
		vac[47:32] = 16'd800;
		vac[127:112] = 16'd800;
		cyc(8);
		chk(valve_drive[2], 1);
		chk(valve_drive[7], 0);
		rc(2);
		chk(cb[CB_VALVE], 1);
		rc(7);
		chk(cb[CB_VALVE], 0);
		$display("test valve protection done");
		// Leak period is five ticks of ten cycles, limit 100 mbar per period
		air_save_en[6] = 1;
		leak_mon_en[6] = 1;
		vac[111:96] = 16'd800;
		suck_req[6] = 1;
		cyc(5);
		vac[111:96] = 16'd720;
		cyc(60);
		chk(valve_drive[6], 0);
		vac[111:96] = 16'd610;
		cyc(60);
		chk(valve_drive[6], 1);
		rc(6);
		chk(cb[CB_LEAK], 0);
		vac[111:96] = 16'd800;
		cyc(5);
		vac[111:96] = 16'd690;
		cyc(60);
		rc(6);
		chk(cb[CB_LEAK], 1);
		vac[111:96] = 16'd800;
		cyc(5);
		chk(valve_drive[6], 1);
		$display("test leakage done");
		vac[79:64] = 16'd580;
		suck_req[4] = 1;
		cyc(220);
		rc(4);
		chk(cb[CB_FREE], 1);
		suck_req[4] = 0;
		$display("test free flow done");
		manual_req[5] = 1;
		manual_valve[5] = 1;
		cyc(3);
		rc(5);
		chk(cb[CB_MAN], 1);
		chk(valve_drive[5], 1);
		us_under = 1;
		cyc(6);
		chk(valve_drive, 16'h0000);
		chk(volt_fault, 1);
		chk(cu_condition[CU_US], 1);
		rc(5);
		chk(cb[CB_MAN], 0);
		us_under = 0;
		ua_over = 1;
		us_over = 1;
		cyc(6);
		chk(cu_condition[CU_UA], 1);
		chk(cu_condition[CU_US], 1);
		// Blink half period is 256 ticks, so one low phase comes within this bound
		for (int n = 0; n < 5200 && bus_led; n++) cyc(1);
		chk(bus_led, 0);
		ua_over = 0;
		us_over = 0;
		cyc(8);
		chk(bus_led, 1);
		$display("test supply done");
		ctl.set_press(1'b1, 16'h1234);
		cyc(3);
		chk(eff_pressure, 16'h1234);
		ctl.set_press(1'b0, 16'h1234);
		cyc(3);
		chk(eff_pressure, OPT_PRESS);
		arst_n = 0;
		cyc(2);
		arst_n = 1;
		ctl.xfer(1'b0, OFS_CTRL, 4'h3, 16'h0, r);
		chk(r.rdata, CTRL_RST);
		rc(2);
		chk(cb, 8'h00);
		$display("test pressure and reset done");
		results();
	end
endmodule // tb
`default_nettype wire

// ==== src/ecm_monitor.sv ====
// Sixteen-ejector condition monitor: switch points, valve protection, evacuation,
// leakage, threshold, free-flow and supply supervision, plus the parameter port.
// Vacuum, suction and mode inputs come from logic on clk; supply comparators are pins.
`timescale 1ns/1ps
`default_nettype none

module ecm_monitor
	import ecm_pkg::*;
#(
	parameter int unsigned N_EJ       = 16,
	parameter int unsigned TICK_CYCLES = TICK_CYC,
	parameter int unsigned WIN_MS      = SWF_WIN_MS,
	parameter int unsigned LEAK_PER_MS = LEAK_MS
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                arst_n,
	// Parameter port
	input  wire ecm_req_s            par_req,
	output ecm_rsp_s                 par_rsp,
	// Ejector process side
	input  wire logic [N_EJ-1:0]     suck_req,
	input  wire logic [N_EJ-1:0]     air_save_en,
	input  wire logic [N_EJ-1:0]     leak_mon_en,
	input  wire logic [N_EJ-1:0]     fallback_dis,
	input  wire logic [N_EJ-1:0]     manual_req,
	input  wire logic [N_EJ-1:0]     manual_valve,
	input  wire logic [N_EJ*16-1:0]  vacuum,
	input  wire logic [15:0]         evac_limit_ms,
	input  wire logic [15:0]         leak_limit,
	input  wire logic                press_valid,
	input  wire logic [15:0]         press_level,
	// Supply comparators
	input  wire logic                us_under,
	input  wire logic                us_over,
	input  wire logic                ua_under,
	input  wire logic                ua_over,
	// Outputs
	output logic [N_EJ-1:0]          valve_drive,
	output logic [N_EJ-1:0]          check_led,
	output logic [N_EJ-1:0]          ctrl_reached,
	output logic [7:0]               cu_condition,
	output logic                     volt_fault,
	output logic                     status_yellow,
	output logic                     bus_led,
	output logic [15:0]              eff_pressure
);

	// ==========================================================
	// Time base
	logic [31:0] div_r;
	logic        tick;
	logic [15:0] now_r;

	assign tick = (div_r == 32'(TICK_CYCLES - 1));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_r <= '0;
			now_r <= '0;
		end else if (tick) begin
			div_r <= '0;
			now_r <= now_r + 16'h0001;
		end else begin
			div_r <= div_r + 32'h0000_0001;
		end
	end

	// ==========================================================
	// Supply supervision
	logic [3:0] sup_m_r;
	logic [3:0] sup_s_r;
	logic       under_v;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sup_m_r <= '0;
			sup_s_r <= '0;
		end else begin
			sup_m_r <= {ua_over, ua_under, us_over, us_under};
			sup_s_r <= sup_m_r;
		end
	end

	assign under_v = sup_s_r[0] | sup_s_r[2];

	// ==========================================================
	// Parameter store
	ecm_par_s    par_r [N_EJ];
	logic [7:0]  cond_r [N_EJ];
	ecm_par_s    cur;
	logic [16:0] w17;
	logic        ok;

	assign cur = par_r[par_req.idx];
	assign w17 = {1'b0, par_req.wdata};

	always_comb begin
		ok = 1'b0;
		case (par_req.ofs)
			OFS_CTRL:   ok = (w17 <= CTRL_MAX) &&
				(w17 >= {1'b0, cur.chk} + {1'b0, cur.ctrl_h});
			OFS_CTRL_H: ok = (w17 > HYST_MIN) &&
				({1'b0, cur.chk} + w17 <= {1'b0, cur.ctrl});
			OFS_CHK:    ok = (w17 >= {1'b0, cur.chk_h} + CHK_GAP) &&
				(w17 + {1'b0, cur.ctrl_h} <= {1'b0, cur.ctrl});
			OFS_CHK_H:  ok = (w17 >= HYST_MIN) && (w17 + CHK_GAP <= {1'b0, cur.chk});
			default:    ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int k = 0; k < N_EJ; k++) begin
				par_r[k] <= '{ctrl: CTRL_RST, ctrl_h: CTRL_H_RST, chk: CHK_RST, chk_h: CHK_H_RST};
			end
		end else if (par_req.wr && ok) begin
			case (par_req.ofs)
				OFS_CTRL:   par_r[par_req.idx].ctrl   <= par_req.wdata;
				OFS_CTRL_H: par_r[par_req.idx].ctrl_h <= par_req.wdata;
				OFS_CHK:    par_r[par_req.idx].chk    <= par_req.wdata;
				OFS_CHK_H:  par_r[par_req.idx].chk_h  <= par_req.wdata;
				default:    par_r[par_req.idx] <= par_r[par_req.idx];
			endcase
		end
	end

	// Answer one cycle after the request; condition bytes refuse writes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			par_rsp <= '0;
		end else begin
			par_rsp.ack <= par_req.wr | par_req.rd;
			par_rsp.err <= par_req.wr & ~ok;
			if (par_req.rd) begin
				case (par_req.ofs)
					OFS_CTRL:   par_rsp.rdata <= cur.ctrl;
					OFS_CTRL_H: par_rsp.rdata <= cur.ctrl_h;
					OFS_CHK:    par_rsp.rdata <= cur.chk;
					OFS_CHK_H:  par_rsp.rdata <= cur.chk_h;
					OFS_COND:   par_rsp.rdata <= {8'h00, cond_r[par_req.idx]};
					default:    par_rsp.rdata <= '0;
				endcase
				if (!(par_req.ofs inside {OFS_CTRL, OFS_CTRL_H, OFS_CHK, OFS_CHK_H, OFS_COND})) begin
					par_rsp.err <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Per-ejector supervision
	genvar g;
	generate
		for (g = 0; g < N_EJ; g++) begin : g_ej
			logic [15:0] vac;
			logic [16:0] ctrl_lo;
			logic [16:0] chk_lo;
			logic        at_ctrl;
			logic        below_ctrl_lo;
			logic        at_chk;
			logic        start;
			logic        stop;
			logic        save_eff;
			logic        toggle;
			logic        leak_chk;
			logic [15:0] loss;
			logic        cyc_r;
			logic        valve_r;
			logic        valve_prev_r;
			logic        swf_fb_r;
			logic        leak_fb_r;
			logic [2:0]  sw_cnt_r;
			logic [15:0] ts_r [SWF_MAX+1];
			logic [15:0] leak_t_r;
			logic [15:0] leak_ref_r;
			logic [1:0]  leak_n_r;
			logic        leak_kick_r;
			logic        evac_on_r;
			logic [15:0] evac_t_r;
			logic        reached_r;
			logic [15:0] ff_t_r;
			logic        ff_done_r;
			logic        man_r;
			logic        man_prev_r;

			assign vac           = vacuum[g*16 +: 16];
			assign ctrl_lo       = {1'b0, par_r[g].ctrl} - {1'b0, par_r[g].ctrl_h};
			assign chk_lo        = {1'b0, par_r[g].chk} - {1'b0, par_r[g].chk_h};
			assign at_ctrl       = vac >= par_r[g].ctrl;
			assign below_ctrl_lo = {1'b0, vac} < ctrl_lo;
			assign at_chk        = vac >= par_r[g].chk;
			assign start         = suck_req[g] & ~cyc_r;
			assign stop          = ~suck_req[g] & cyc_r;
			assign save_eff      = air_save_en[g] & ~swf_fb_r & ~leak_fb_r;
			assign toggle        = suck_req[g] & save_eff & (valve_r != valve_prev_r);
			assign leak_chk      = tick && (leak_t_r == 16'(LEAK_PER_MS - 1));
			assign loss          = (vac < leak_ref_r) ? (leak_ref_r - vac) : 16'h0000;

			// Air-saving two-point control of the suction valve
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					cyc_r        <= 1'b0;
					valve_r      <= 1'b0;
					valve_prev_r <= 1'b0;
				end else begin
					cyc_r        <= suck_req[g];
					valve_prev_r <= valve_r;
					if (!suck_req[g]) begin
						valve_r <= 1'b0;
					end else if (start || !save_eff || leak_kick_r) begin
						valve_r <= 1'b1;
					end else if (at_ctrl) begin
						valve_r <= 1'b0;
					end else if (below_ctrl_lo) begin
						valve_r <= 1'b1;
					end
				end
			end

			// Switch-frequency guard: seventh switch inside the window trips it
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					swf_fb_r <= 1'b0;
					sw_cnt_r <= '0;
					for (int k = 0; k <= SWF_MAX; k++) begin
						ts_r[k] <= '0;
					end
				end else if (start) begin
					swf_fb_r <= 1'b0;
					sw_cnt_r <= '0;
				end else if (toggle) begin
					ts_r[0] <= now_r;
					for (int k = 1; k <= SWF_MAX; k++) begin
						ts_r[k] <= ts_r[k-1];
					end
					if (sw_cnt_r != 3'(SWF_MAX)) begin
						sw_cnt_r <= sw_cnt_r + 3'h1;
					end else if ((now_r - ts_r[SWF_MAX-1]) < 16'(WIN_MS) && !fallback_dis[g]) begin
						swf_fb_r <= 1'b1;
					end
				end
			end

			// Leakage per second while the valve rests
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					leak_t_r    <= '0;
					leak_ref_r  <= '0;
					leak_n_r    <= '0;
					leak_fb_r   <= 1'b0;
					leak_kick_r <= 1'b0;
				end else begin
					leak_kick_r <= 1'b0;
					if (start) begin
						leak_n_r  <= '0;
						leak_fb_r <= 1'b0;
					end
					if (valve_r || !suck_req[g]) begin
						leak_t_r   <= '0;
						leak_ref_r <= vac;
					end else if (leak_chk) begin
						leak_t_r   <= '0;
						leak_ref_r <= vac;
						if (leak_mon_en[g] && loss > leak_limit) begin
							leak_kick_r <= 1'b1;
							if (leak_n_r != 2'(LEAK_MAX)) begin
								leak_n_r <= leak_n_r + 2'h1;
							end
							if (leak_n_r == 2'(LEAK_MAX - 1) && !fallback_dis[g]) begin
								leak_fb_r <= 1'b1;
							end
						end
					end else if (tick) begin
						leak_t_r <= leak_t_r + 16'h0001;
					end
				end
			end

			// Evacuation time, threshold reach and free-flow sampling
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					evac_on_r <= 1'b0;
					evac_t_r  <= '0;
					reached_r <= 1'b0;
					ff_t_r    <= '0;
					ff_done_r <= 1'b0;
				end else if (start) begin
					evac_on_r <= 1'b0;
					evac_t_r  <= '0;
					reached_r <= 1'b0;
					ff_t_r    <= '0;
					ff_done_r <= 1'b0;
				end else if (suck_req[g]) begin
					if (at_ctrl) begin
						reached_r <= 1'b1;
						evac_on_r <= 1'b0;
					end else if (at_chk && !reached_r) begin
						evac_on_r <= 1'b1;
					end
					if (evac_on_r && tick && evac_t_r != 16'hffff) begin
						evac_t_r <= evac_t_r + 16'h0001;
					end
					if (tick && !ff_done_r) begin
						ff_t_r <= ff_t_r + 16'h0001;
						if (ff_t_r == 16'(FF_SET_MS - 1)) begin
							ff_done_r <= 1'b1;
						end
					end
				end
			end

			// Manual operation, dropped on undervoltage
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					man_r      <= 1'b0;
					man_prev_r <= 1'b0;
				end else begin
					man_prev_r <= manual_req[g];
					if (under_v || !manual_req[g]) begin
						man_r <= 1'b0;
					end else if (!man_prev_r) begin
						man_r <= 1'b1;
					end
				end
			end

			// Condition byte; a new event in the start cycle still lands
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					cond_r[g] <= '0;
				end else begin
					if (start) begin
						cond_r[g][CB_VALVE] <= 1'b0;
						cond_r[g][CB_EVAC]  <= 1'b0;
						cond_r[g][CB_LEAK]  <= 1'b0;
						cond_r[g][CB_THR]   <= 1'b0;
					end
					if (swf_fb_r) begin
						cond_r[g][CB_VALVE] <= 1'b1;
					end
					if (evac_on_r && evac_t_r > evac_limit_ms) begin
						cond_r[g][CB_EVAC] <= 1'b1;
					end
					if (leak_fb_r) begin
						cond_r[g][CB_LEAK] <= 1'b1;
					end
					if (stop && !reached_r) begin
						cond_r[g][CB_THR] <= 1'b1;
					end
					if (suck_req[g] && !start && tick && !ff_done_r && ff_t_r == 16'(FF_SET_MS - 1)) begin
						cond_r[g][CB_FREE] <= ({1'b0, vac} > chk_lo) && !at_ctrl;
					end
					cond_r[g][CB_MAN] <= man_r;
				end
			end

			// Valve drive and indicators
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					valve_drive[g]  <= 1'b0;
					check_led[g]    <= 1'b0;
					ctrl_reached[g] <= 1'b0;
				end else begin
					valve_drive[g]  <= ~under_v & (man_r ? manual_valve[g] : valve_r);
					ctrl_reached[g] <= at_ctrl;
					if (at_chk) begin
						check_led[g] <= 1'b1;
					end else if ({1'b0, vac} < chk_lo) begin
						check_led[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// Control-unit status
	logic ej_warn;

	always_comb begin
		ej_warn = 1'b0;
		for (int k = 0; k < N_EJ; k++) begin
			ej_warn = ej_warn | (|cond_r[k][CB_FREE:CB_VALVE]);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cu_condition  <= '0;
			volt_fault    <= 1'b0;
			status_yellow <= 1'b0;
			bus_led       <= 1'b0;
			eff_pressure  <= OPT_PRESS;
		end else begin
			cu_condition          <= '0;
			cu_condition[CU_US]   <= sup_s_r[0] | sup_s_r[1];
			cu_condition[CU_UA]   <= sup_s_r[2] | sup_s_r[3];
			cu_condition[CU_WARN] <= ej_warn;
			volt_fault            <= |sup_s_r;
			status_yellow         <= ej_warn;
			bus_led               <= ~(|sup_s_r) | now_r[BLINK_BIT];
			eff_pressure          <= press_valid ? press_level : OPT_PRESS;
		end
	end

endmodule // ecm_monitor

`default_nettype wire

// ==== src/ecm_pkg.sv ====
// Constants, parameter map and carrier types of the ejector condition monitor.
// Assumes one 50 MHz clock and parameter access by offset and ejector index.
// Functional notes
// - Condition byte: bit0 valve protection, then evacuation, leakage, threshold, free-flow, bit5 manual.
// - Sixteen read-only condition bytes, index 0..15, reset to zero, volatile.
// - Air saving with more than six valve switches in three seconds falls back.
// - After that fallback the ejector keeps sucking, warns, sets valve protection.
// - Evacuation time from check point to control point over limit sets flag.
// - In control mode leakage is measured in mbar per second against a limit.
// - Leakage under limit: decay to control point minus hysteresis, then suck, no warning.
// - Leakage over limit readjusts at once; second excess forces suction and flags.
// - Control point never reached in a suction cycle sets threshold-missed flag.
// - Threshold-missed flag valid at suction end, held until next cycle starts.
// - Free-flow sample 20 ms after cycle start; above check-minus-hysteresis and below control flags.
// - Supply voltage out of range updates status, condition data and flashes bus indicator.
// - Undervoltage stops valve drive so each ejector returns to its base state.
// - Undervoltage ends manual operation.
// - Overvoltage also raises a condition monitoring event.
// - Supply pressure from the controller is used, else the optimum pressure.
// - Vacuum is compared with both points; indicator lit while check point reached.
// - Control point 16 bit, 998 >= value >= check + control hysteresis, default 750.
// - Control hysteresis above 10, at most control minus check, default 150.
// - Check point between check hysteresis + 2 and control minus hysteresis, default 550.
// - Check hysteresis at least 10, at most check minus 2, default 10.
// - Flags clear at cycle start and hold; free-flow flag changes only on measurement; a fallback or overdue evacuation pending at start keeps its flag.
// - Air saving stops at control point, restarts below control minus hysteresis.
package ecm_pkg;

	localparam int unsigned CLK_MHZ    = 50;
	localparam int unsigned TICK_US    = 1000;
	localparam int unsigned TICK_CYC   = TICK_US * CLK_MHZ;
	localparam int unsigned SWF_WIN_MS = 3000;
	localparam int unsigned SWF_MAX    = 6;
	localparam int unsigned LEAK_MS    = 1000;
	localparam int unsigned LEAK_MAX   = 2;
	localparam int unsigned FF_SET_MS  = 20;
	localparam int unsigned BLINK_BIT  = 8;

	// Parameter offsets
	localparam logic [15:0] OFS_CTRL   = 16'h0064;
	localparam logic [15:0] OFS_CTRL_H = 16'h0065;
	localparam logic [15:0] OFS_CHK    = 16'h0066;
	localparam logic [15:0] OFS_CHK_H  = 16'h0067;
	localparam logic [15:0] OFS_COND   = 16'h0092;

	localparam logic [15:0] CTRL_RST   = 16'h02ee;
	localparam logic [15:0] CTRL_H_RST = 16'h0096;
	localparam logic [15:0] CHK_RST    = 16'h0226;
	localparam logic [15:0] CHK_H_RST  = 16'h000a;
	localparam logic [16:0] CTRL_MAX   = 17'h003e6;
	localparam logic [16:0] HYST_MIN   = 17'h0000a;
	localparam logic [16:0] CHK_GAP    = 17'h00002;
	localparam logic [15:0] OPT_PRESS  = 16'h0000;

	// Condition byte fields
	localparam int unsigned CB_VALVE = 0;
	localparam int unsigned CB_EVAC  = 1;
	localparam int unsigned CB_LEAK  = 2;
	localparam int unsigned CB_THR   = 3;
	localparam int unsigned CB_FREE  = 4;
	localparam int unsigned CB_MAN   = 5;

	// Control-unit condition byte fields
	localparam int unsigned CU_US   = 0;
	localparam int unsigned CU_UA   = 1;
	localparam int unsigned CU_WARN = 3;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [15:0] ctrl_h;
		logic [15:0] chk;
		logic [15:0] chk_h;
	} ecm_par_s;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] ofs;
		logic [3:0]  idx;
		logic [15:0] wdata;
	} ecm_req_s;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [15:0] rdata;
	} ecm_rsp_s;

endpackage
